// ---- verilog/voltage_protection_stage.sv ----
// module: decision logic of one over/undervoltage protection stage
//
// Overview of operation
// R1 - loss of potential below 0.03 of nominal blocks undervoltage operation.
// R2 - software must not set undervoltage pickup far below the loss level.
// R3 - one structure serves as overvoltage, undervoltage, or unused stage.
// R4 - phase-to-neutral wiring: flags a/b/c follow phase voltages 1, 2, 3.
// R5 - phase-to-phase wiring: flags a/b/c follow voltages 1-2, 2-3, 3-1.
// R6 - measure fundamental, true RMS or sliding average, chosen per stage.
// R7 - average method supervises a sliding average over ten minutes.
// R8 - ground wiring: nominal is rating/sqrt3 or rating per measuring mode.
// R9 - phase wiring forces phase-to-phase mode, nominal equals the rating.
// R10 - pickup voting: any one, any two, or all three phases.
// R11 - settable dropout ratio sets the release level of a pickup.
// R12 - either external block input blocks the stage when permitted.
// R13 - external trip block suppresses only the trip when permitted.
// R14 - function setting enables the stage; only the first is on by default.
// R15 - permission bit decides whether external block inputs act at all.
// R16 - permanent setting suppresses the trip regardless of block inputs.
// R17 - trip follows alarm after the delay; clears on dropout or block.
`timescale 1ns/1ns
`default_nettype none
module voltage_protection_stage
	import vprot_pkg::*;
#(
	parameter int          STAGE_NUM       = 1,
	parameter int unsigned AVG_SLOT_CYCLES = vprot_pkg::AVG_SLOT_CYCLES
) (
	// clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             rst_n_i,
	// measured channels, three per method, one sample per valid pulse
	input  wire logic             sample_valid_i,
	input  wire logic [V_W-1:0]   fund_ch1_i,
	input  wire logic [V_W-1:0]   fund_ch2_i,
	input  wire logic [V_W-1:0]   fund_ch3_i,
	input  wire logic [V_W-1:0]   rms_ch1_i,
	input  wire logic [V_W-1:0]   rms_ch2_i,
	input  wire logic [V_W-1:0]   rms_ch3_i,
	// field settings
	input  wire logic             transformer_wiring_setting_i,
	input  wire logic [V_W-1:0]   vt_secondary_rating_i,
	// stage settings
	input  wire logic             stage_function_wr_i,
	input  wire logic             stage_function_i,
	input  wire logic [1:0]       stage_mode_i,
	input  wire logic [1:0]       meas_method_i,
	input  wire logic             meas_mode_i,
	input  wire logic [1:0]       vote_mode_i,
	input  wire logic [15:0]      pickup_pu_i,
	input  wire logic [15:0]      dropout_ratio_i,
	input  wire logic [31:0]      trip_delay_i,
	input  wire logic             external_block_permission_i,
	input  wire logic             external_trip_block_permission_i,
	input  wire logic             permanent_trip_suppress_i,
	// external block signals
	input  wire logic             external_block_input_a_i,
	input  wire logic             external_block_input_b_i,
	input  wire logic             external_trip_block_input_i,
	// per-phase flags
	output logic                  stage_alarm_phase_a_o,
	output logic                  stage_alarm_phase_b_o,
	output logic                  stage_alarm_phase_c_o,
	output logic                  stage_trip_phase_a_o,
	output logic                  stage_trip_phase_b_o,
	output logic                  stage_trip_phase_c_o,
	// stage status
	output logic                  stage_alarm_o,
	output logic                  stage_trip_o,
	output logic                  stage_blocked_o,
	output logic                  loss_of_potential_supervisor_o,
	output logic [V_W-1:0]        nominal_voltage_reference_o
);

	// ==========================================================
	// declarations
	logic [V_W-1:0]   fund_v [3];
	logic [V_W-1:0]   rms_v  [3];
	logic [V_W-1:0]   avg_v  [3];
	logic [2:0]       avg_ok;
	logic [V_W-1:0]   meas_v [3];
	logic [2:0]       pick_q;
	logic [2:0]       alarm_ph_q;
	logic             alarm_q;
	logic [2:0]       trip_ph_q;
	logic             trip_q;
	logic             func_q;
	logic             lop_q;
	logic             blocked_q;
	logic [V_W-1:0]   vn_q;
	logic [V_W-1:0]   vn_d;
	logic [V_W+16:0]  vn_scaled;
	logic [V_W+16:0]  lop_prod;
	logic [V_W-1:0]   lop_thr;
	logic [THR_W+15:0] pick_prod;
	logic [THR_W-1:0]  pick_thr;
	logic [THR_W+15:0] rel_prod;
	logic [THR_W-1:0]  rel_thr;
	logic             is_over;
	logic             is_under;
	logic             blocked_d;
	logic             trip_block;
	logic [1:0]       n_pick;
	logic             vote_d;
	logic [31:0]      trip_cnt_q;
	trip_state_e      trip_st_q;

	// channel index 0/1/2 is phase 1/2/3 or pair 1-2/2-3/3-1 as wired
	assign fund_v[0] = fund_ch1_i; // R4 R5
	assign fund_v[1] = fund_ch2_i;
	assign fund_v[2] = fund_ch3_i;
	assign rms_v[0]  = rms_ch1_i;
	assign rms_v[1]  = rms_ch2_i;
	assign rms_v[2]  = rms_ch3_i;

	// ==========================================================
	// nominal reference
	// phase wiring overrides the stage's measuring mode
	assign vn_scaled = vt_secondary_rating_i * INV_SQRT3_Q16;
	always_comb begin
		if (transformer_wiring_setting_i == WIRING_PH_PHASE) begin
			vn_d = vt_secondary_rating_i; // R9
		end else if (meas_mode_i == MEAS_PH_GROUND) begin
			vn_d = vn_scaled[V_W+15:16]; // R8
		end else begin
			vn_d = vt_secondary_rating_i; // R8
		end
	end

	// reference register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vn_q <= '0;
		end else begin
			vn_q <= vn_d;
		end
	end

	// ==========================================================
	// thresholds from the per-unit settings
	assign pick_prod = THR_W'(vn_q) * pickup_pu_i;
	assign pick_thr  = pick_prod[THR_W+PU_FRAC-1:PU_FRAC];
	// release level: below 1 for overvoltage, above 1 for undervoltage
	assign rel_prod  = pick_thr * dropout_ratio_i; // R11
	assign rel_thr   = rel_prod[THR_W+PU_FRAC-1:PU_FRAC];
	assign lop_prod  = vn_q * LOP_FRAC_Q16;
	assign lop_thr   = lop_prod[V_W+15:16];

	assign is_over  = (stage_mode_e'(stage_mode_i) == MODE_OVER);  // R3
	assign is_under = (stage_mode_e'(stage_mode_i) == MODE_UNDER); // R3

	// ==========================================================
	// per-phase measurement selection and hysteresis
	for (genvar p = 0; p < 3; p++) begin : g_phase
		sliding_average #(
			.W           (V_W),
			.SLOTS       (AVG_SLOTS),
			.SLOTS_LOG2  (AVG_SLOTS_LOG2),
			.SLOT_CYCLES (AVG_SLOT_CYCLES)
		) u_avg (
			.clk_sys_i   (clk_sys_i),
			.rst_n_i     (rst_n_i),
			.sample_i    (rms_v[p]),
			.avg_o       (avg_v[p]),
			.avg_valid_o (avg_ok[p])
		); // R7

		// method select
		always_comb begin
			case (meas_method_e'(meas_method_i))
				METHOD_FUND: meas_v[p] = fund_v[p]; // R6
				METHOD_RMS:  meas_v[p] = rms_v[p];  // R6
				METHOD_AVG:  meas_v[p] = avg_v[p];  // R6
				default:     meas_v[p] = fund_v[p];
			endcase
		end

		// pickup with dropout hysteresis; an average not yet filled never picks up
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				pick_q[p] <= 1'b0;
			end else if (!(is_over || is_under)) begin
				pick_q[p] <= 1'b0;
			end else if (meas_method_e'(meas_method_i) == METHOD_AVG && !avg_ok[p]) begin
				pick_q[p] <= 1'b0;
			end else if (sample_valid_i) begin
				if (is_over) begin
					pick_q[p] <= pick_q[p] ? (THR_W'(meas_v[p]) >= rel_thr)
					                       : (THR_W'(meas_v[p]) > pick_thr); // R11
				end else begin
					pick_q[p] <= pick_q[p] ? (THR_W'(meas_v[p]) <= rel_thr)
					                       : (THR_W'(meas_v[p]) < pick_thr); // R11
				end
			end
		end
	end

	// ==========================================================
	// loss of potential: all three channels under 3 % of nominal
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lop_q <= 1'b0;
		end else if (sample_valid_i) begin
			lop_q <= (fund_v[0] < lop_thr) && (fund_v[1] < lop_thr)
			         && (fund_v[2] < lop_thr); // R1
		end
	end

	// ==========================================================
	// function enable, default on for the first stage only
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			func_q <= (STAGE_NUM == 1); // R14
		end else if (stage_function_wr_i) begin
			func_q <= stage_function_i; // R14
		end
	end

	// ==========================================================
	// blocking
	// an unassigned block input is expected to be held low
	assign blocked_d = !func_q || !(is_over || is_under)
	                   || (external_block_permission_i
	                       && (external_block_input_a_i || external_block_input_b_i)) // R12 R15
	                   || (is_under && lop_q); // R1
	assign trip_block = permanent_trip_suppress_i // R16
	                    || (external_trip_block_permission_i
	                        && external_trip_block_input_i); // R13

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			blocked_q <= 1'b1;
		end else begin
			blocked_q <= blocked_d;
		end
	end

	// ==========================================================
	// voting and alarm
	assign n_pick = 2'(pick_q[0]) + 2'(pick_q[1]) + 2'(pick_q[2]);
	always_comb begin
		case (vote_e'(vote_mode_i))
			VOTE_ANY_ONE: vote_d = (n_pick >= 2'd1); // R10
			VOTE_ANY_TWO: vote_d = (n_pick >= 2'd2); // R10
			VOTE_ALL:     vote_d = (n_pick == 2'd3); // R10
			default:      vote_d = (n_pick >= 2'd1);
		endcase
	end

	// a blocked stage shows no alarm at all
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			alarm_q    <= 1'b0;
			alarm_ph_q <= 3'h0;
		end else if (blocked_d) begin
			alarm_q    <= 1'b0;
			alarm_ph_q <= 3'h0;
		end else begin
			alarm_q    <= vote_d;
			alarm_ph_q <= vote_d ? pick_q : 3'h0;
		end
	end

	// ==========================================================
	// trip delay timer
	// the delay counts from the registered alarm, so trip lags it by the delay
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trip_st_q  <= TRIP_IDLE;
			trip_cnt_q <= TRIP_CNT_RESET;
			trip_q     <= 1'b0;
			trip_ph_q  <= 3'h0;
		end else if (!alarm_q || blocked_d || trip_block) begin // R12
			trip_st_q  <= TRIP_IDLE; // R17
			trip_cnt_q <= TRIP_CNT_RESET;
			trip_q     <= 1'b0;
			trip_ph_q  <= 3'h0;
		end else begin
			case (trip_st_q)
				TRIP_IDLE: begin
					trip_cnt_q <= 32'd1;
					if (trip_delay_i <= 32'd1) begin
						trip_st_q <= TRIP_TRIPPED;
						trip_q    <= 1'b1;
						trip_ph_q <= alarm_ph_q;
					end else begin
						trip_st_q <= TRIP_TIMING;
					end
				end
				TRIP_TIMING: begin
					trip_cnt_q <= trip_cnt_q + 32'd1;
					if (trip_cnt_q + 32'd1 >= trip_delay_i) begin
						trip_st_q <= TRIP_TRIPPED; // R17
						trip_q    <= 1'b1;
						trip_ph_q <= alarm_ph_q;
					end
				end
				TRIP_TRIPPED: begin
					trip_ph_q <= alarm_ph_q;
				end
				default: begin
					trip_st_q <= TRIP_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// outputs, all straight from flip-flops
	assign stage_alarm_phase_a_o          = alarm_ph_q[0]; // R4 R5
	assign stage_alarm_phase_b_o          = alarm_ph_q[1];
	assign stage_alarm_phase_c_o          = alarm_ph_q[2];
	assign stage_trip_phase_a_o           = trip_ph_q[0];
	assign stage_trip_phase_b_o           = trip_ph_q[1];
	assign stage_trip_phase_c_o           = trip_ph_q[2];
	assign stage_alarm_o                  = alarm_q;
	assign stage_trip_o                   = trip_q;
	assign stage_blocked_o                = blocked_q;
	assign loss_of_potential_supervisor_o = lop_q;
	assign nominal_voltage_reference_o    = vn_q;

endmodule : voltage_protection_stage
`default_nettype wire

// ---- common/vprot_pkg.sv ----
// package: constants and enumerations for the voltage protection stage
package vprot_pkg;

	// ==========================================================
	// widths and fixed-point formats
	localparam int V_W     = 16;                 // measured magnitude width
	localparam int PU_FRAC = 8;                  // per-unit settings are Q8.8
	localparam int THR_W   = V_W + 8;            // threshold width, pickup fits; release can overflow

	// ==========================================================
	// nominal reference and loss-of-potential level, Q0.16 fractions
	localparam logic [16:0] INV_SQRT3_Q16 = 17'h093CD; // 1/sqrt(3)
	localparam logic [16:0] LOP_FRAC_Q16  = 17'h007AE; // 0.03 of nominal

	// ==========================================================
	// sliding average timing
	localparam int    CLK_HZ          = 20_000_000;
	localparam int    AVG_WINDOW_MIN  = 10;       // averaging window in minutes
	localparam int    AVG_SLOTS       = 16;       // decimated samples per window
	localparam int    AVG_SLOTS_LOG2  = 4;
	localparam longint AVG_SLOT_CYC_L = (longint'(AVG_WINDOW_MIN) * 60 * CLK_HZ) / AVG_SLOTS;
	localparam int unsigned AVG_SLOT_CYCLES = int'(AVG_SLOT_CYC_L);

	// ==========================================================
	// reset values
	localparam logic [31:0] TRIP_CNT_RESET = 32'h0000_0000;

	// ==========================================================
	// settings encodings
	typedef enum logic [1:0] {
		MODE_UNUSED = 2'h0,
		MODE_OVER   = 2'h1,
		MODE_UNDER  = 2'h2
	} stage_mode_e;

	typedef enum logic [1:0] {
		METHOD_FUND = 2'h0,
		METHOD_RMS  = 2'h1,
		METHOD_AVG  = 2'h2
	} meas_method_e;

	typedef enum logic [1:0] {
		VOTE_ANY_ONE = 2'h0,
		VOTE_ANY_TWO = 2'h1,
		VOTE_ALL     = 2'h2
	} vote_e;

	localparam logic WIRING_PH_NEUTRAL = 1'b0;
	localparam logic WIRING_PH_PHASE   = 1'b1;
	localparam logic MEAS_PH_GROUND    = 1'b0;
	localparam logic MEAS_PH_PHASE     = 1'b1;

	// trip timer states
	typedef enum logic [2:0] {
		TRIP_IDLE    = 3'b001,
		TRIP_TIMING  = 3'b010,
		TRIP_TRIPPED = 3'b100
	} trip_state_e;

endpackage : vprot_pkg

// ---- verilog/sliding_average.sv ----
// module: decimated sliding average of one voltage channel
`timescale 1ns/1ns
`default_nettype none
module sliding_average
	import vprot_pkg::*;
#(
	parameter int          W           = V_W,
	parameter int          SLOTS       = AVG_SLOTS,
	parameter int          SLOTS_LOG2  = AVG_SLOTS_LOG2,
	parameter int unsigned SLOT_CYCLES = AVG_SLOT_CYCLES
) (
	// clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	// sample in
	input  wire logic [W-1:0] sample_i,
	// average out
	output logic      [W-1:0] avg_o,
	output logic              avg_valid_o
);

	// ==========================================================
	// storage
	logic [W-1:0]            slot_q [SLOTS];
	logic [SLOTS_LOG2-1:0]   ptr_q;
	logic [W+SLOTS_LOG2-1:0] sum_q;
	logic [31:0]             tick_cnt_q;
	logic                    full_q;
	logic                    tick;

	// one slot per window/SLOTS; decimating keeps the memory small at the cost
	// of ignoring what happens between ticks
	assign tick = (tick_cnt_q == SLOT_CYCLES - 32'd1);

	// slot period counter
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_q <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt_q <= 32'h0000_0000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'd1;
		end
	end

	// slot store, one entry per generate branch
	for (genvar g = 0; g < SLOTS; g++) begin : g_slot
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				slot_q[g] <= '0;
			end else if (tick && ptr_q == SLOTS_LOG2'(g)) begin
				slot_q[g] <= sample_i;
			end
		end
	end

	// running sum: add newest, drop the one it replaces
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sum_q  <= '0;
			ptr_q  <= '0;
			full_q <= 1'b0;
		end else if (tick) begin
			sum_q <= sum_q + (W+SLOTS_LOG2)'(sample_i) - (W+SLOTS_LOG2)'(slot_q[ptr_q]);
			ptr_q <= ptr_q + SLOTS_LOG2'(1);
			if (ptr_q == SLOTS_LOG2'(SLOTS - 1)) begin
				full_q <= 1'b1;
			end
		end
	end

	// average is only meaningful once the whole window has been seen
	assign avg_o       = sum_q[W+SLOTS_LOG2-1:SLOTS_LOG2];
	assign avg_valid_o = full_q;

endmodule : sliding_average
`default_nettype wire

// ---- bench/vprot_source.sv ----
// model: measurement front end that publishes channel magnitudes to the stage
`timescale 1ns/1ns
`default_nettype none
module vprot_source
	import vprot_pkg::*;
#(
	parameter int PERIOD = 4 // cycles between samples
) (
	// clock
	input  wire logic                  clk_sys_i,
	// requested levels, one per channel, and a harmonic share seen only by true RMS
	input  wire logic [2:0][V_W-1:0]   lvl_i,
	input  wire logic      [V_W-1:0]   harm_i,
	// measurements
	output logic                       sample_valid_o,
	output logic      [2:0][V_W-1:0]   fund_o,
	output logic      [2:0][V_W-1:0]   rms_o
);
	int cnt = 0;

	// ==========================================================
	// time zero values, so no measurement input of the stage starts unknown
	initial begin
		sample_valid_o = 1'b0;
		fund_o = '0;
		rms_o = '0;
	end

	// ==========================================================
	// pacing: publish on the falling edge, so values are settled at the stage's edge
	always @(negedge clk_sys_i) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		sample_valid_o <= (cnt == 0);
		if (cnt == 0) begin
			fund_o <= lvl_i;
			for (int i = 0; i < 3; i++) begin
				rms_o[i] <= lvl_i[i] + harm_i;
			end
		end
	end
endmodule : vprot_source
`default_nettype wire

// ---- bench/voltage_protection_stage_properties.sv ----
// checker: timing relations on the ports of the protection stage
`timescale 1ns/1ns
`default_nettype none
module voltage_protection_stage_properties
	import vprot_pkg::*;
#(
	parameter int unsigned AVG_SLOT_CYCLES = 4
) (
	// clock and reset
	input wire logic             clk_sys_i,
	input wire logic             rst_n_i,
	// settings and block inputs
	input wire logic             transformer_wiring_setting_i,
	input wire logic [V_W-1:0]   vt_secondary_rating_i,
	input wire logic [1:0]       stage_mode_i,
	input wire logic             meas_mode_i,
	input wire logic [1:0]       vote_mode_i,
	input wire logic [31:0]      trip_delay_i,
	input wire logic             external_block_permission_i,
	input wire logic             external_trip_block_permission_i,
	input wire logic             permanent_trip_suppress_i,
	input wire logic             external_block_input_a_i,
	input wire logic             external_block_input_b_i,
	input wire logic             external_trip_block_input_i,
	// flags
	input wire logic             stage_alarm_phase_a_o,
	input wire logic             stage_alarm_phase_b_o,
	input wire logic             stage_alarm_phase_c_o,
	input wire logic             stage_trip_phase_a_o,
	input wire logic             stage_alarm_o,
	input wire logic             stage_trip_o,
	input wire logic             stage_blocked_o,
	input wire logic             loss_of_potential_supervisor_o,
	input wire logic [V_W-1:0]   nominal_voltage_reference_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// ==========================================================
	// reset state is checked while reset is held, so it has no disable
	reset_state_a: assert property (disable iff (1'b0) !rst_n_i |-> stage_blocked_o &&
		!stage_alarm_o && !stage_trip_o && nominal_voltage_reference_o == '0)
		else $error("flags wrong during reset");
	vn_ref_a: assert property ((transformer_wiring_setting_i || meas_mode_i) |=>
		nominal_voltage_reference_o == $past(vt_secondary_rating_i))
		else $error("nominal reference differs from rating");
	trip_early_a: assert property ($rose(stage_alarm_o) && trip_delay_i == 32'h5 |->
		!stage_trip_o [*5]) else $error("trip before delay");
	trip_late_a: assert property ($rose(stage_trip_o) && trip_delay_i == 32'h5 |->
		$past(stage_alarm_o, 5) && $past(stage_alarm_o)) else $error("trip without alarm");
	trip_block_a: assert property (((external_trip_block_input_i &&
		external_trip_block_permission_i) || permanent_trip_suppress_i) |=>
		!stage_trip_o && !stage_trip_phase_a_o) else $error("trip not suppressed");
	ext_block_a: assert property ((external_block_input_a_i || external_block_input_b_i) &&
		external_block_permission_i |=> stage_blocked_o && !stage_alarm_o && !stage_trip_o)
		else $error("external block ignored");
	unused_stage_a: assert property ((stage_mode_i == 2'h0 || stage_mode_i == 2'h3) |=>
		stage_blocked_o && !stage_alarm_o) else $error("unused stage active");
	lop_block_a: assert property (loss_of_potential_supervisor_o && stage_mode_i == 2'h2 |->
		##[0:1] stage_blocked_o) else $error("loss of potential did not block");
	// the past term lets picks settle after a vote change
	vote_all_a: assert property (vote_mode_i == 2'h2 && $past(vote_mode_i, 6) == 2'h2 &&
		stage_alarm_o |-> stage_alarm_phase_a_o && stage_alarm_phase_b_o && stage_alarm_phase_c_o)
		else $error("all-phase vote alarm with a phase missing");
endmodule : voltage_protection_stage_properties
`default_nettype wire

// ---- bench/voltage_protection_stage_tb_top.sv ----
// testbench: stage fed by the source model, results checked from a queue of notes
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module voltage_protection_stage_tb_top
	import vprot_pkg::*;
();
	localparam int unsigned SLOT = 4; // short averaging slots
	logic                  clk_sys_i = 1'b0;
	logic                  rst_n_i = 1'b1;
	logic [2:0][V_W-1:0]   lvl, fund, rms;
	logic                  sv, wiring, fwr, fn, mm, eperm, tperm, psup, ba, bb, tb_in;
	logic [1:0]            mode, meth, vote;
	logic [15:0]           rating, pick, drop, harm;
	logic [31:0]           dly;
	logic [2:0]            al, tr;
	logic                  al_s, tr_s, blk, loss_of_potential_supervisor;
	logic [V_W-1:0]        vn, vn_e;
	logic [35:0]           notes[$];
	event                  note_ev;
	int                    checks = 0;
	int                    failures = 0;

	always #25 clk_sys_i = ~clk_sys_i;

	vprot_source #(.PERIOD(4)) src (.clk_sys_i(clk_sys_i), .lvl_i(lvl), .sample_valid_o(sv),
		.harm_i(harm), .fund_o(fund), .rms_o(rms));
	voltage_protection_stage #(.STAGE_NUM(1), .AVG_SLOT_CYCLES(SLOT)) uut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sample_valid_i(sv),
		.fund_ch1_i(fund[0]), .fund_ch2_i(fund[1]), .fund_ch3_i(fund[2]),
		.rms_ch1_i(rms[0]), .rms_ch2_i(rms[1]), .rms_ch3_i(rms[2]),
		.transformer_wiring_setting_i(wiring), .vt_secondary_rating_i(rating),
		.stage_function_wr_i(fwr), .stage_function_i(fn), .stage_mode_i(mode),
		.meas_method_i(meth), .meas_mode_i(mm), .vote_mode_i(vote),
		.pickup_pu_i(pick), .dropout_ratio_i(drop), .trip_delay_i(dly),
		.external_block_permission_i(eperm), .external_trip_block_permission_i(tperm),
		.permanent_trip_suppress_i(psup), .external_block_input_a_i(ba),
		.external_block_input_b_i(bb), .external_trip_block_input_i(tb_in),
		.stage_alarm_phase_a_o(al[2]), .stage_alarm_phase_b_o(al[1]),
		.stage_alarm_phase_c_o(al[0]), .stage_trip_phase_a_o(tr[2]),
		.stage_trip_phase_b_o(tr[1]), .stage_trip_phase_c_o(tr[0]),
		.stage_alarm_o(al_s), .stage_trip_o(tr_s), .stage_blocked_o(blk),
		.loss_of_potential_supervisor_o(loss_of_potential_supervisor), .nominal_voltage_reference_o(vn));

	// ==========================================================
	// helpers; flags are {alarm a b c, trip a b c, alarm, trip, blocked, lop}
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc
	task automatic exp(input logic [9:0] f, input logic [9:0] m = 10'h3FF);
		notes.push_back({vn_e, m, f});
		-> note_ev;
	endtask : exp
	// three sample periods, latency included, so every channel has been re-picked
	task automatic setl(input logic [V_W-1:0] a, b, c);
		lvl = {c, b, a};
		cyc(12);
	endtask : setl
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// ==========================================================
	// monitor: drains every note, a masked flag compare plus the reference
	always @(note_ev) begin : watch
		logic [35:0] n;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			`CHK({al, tr, al_s, tr_s, blk, loss_of_potential_supervisor} & n[19:10], n[9:0] & n[19:10])
			`CHK(vn, n[35:20])
		end
	end

	// a hung run is cut off here and counts as a failure
	initial begin
		cyc(20000);
		failures++;
		$display("mismatch at %0t: run too long", $time);
		report_and_stop();
	end

	// ==========================================================
	// stimulus
	initial begin : main
		int k, m, c;
		logic [V_W-1:0] v[3];
		void'($urandom(1951));
		#1 rst_n_i = 1'b0; // dropped after time zero so the flops cannot miss the edge
		lvl = '0;
		harm = '0;
		{wiring, fwr, fn, mm, eperm, tperm, psup, ba, bb, tb_in} = 10'h284;
		{mode, meth, vote} = {MODE_OVER, METHOD_FUND, VOTE_ANY_ONE};
		rating = 16'h4000;
		pick = 16'h0100;
		drop = 16'h00F0;
		dly = 32'h0000_0FFF;
		vn_e = '0;
		cyc(9);
		exp(10'h002);
		cyc(1);
		rst_n_i = 1'b1;
		vn_e = 16'h4000;
		setl(16'h2000, 16'h2000, 16'h2000);
		exp(10'h000);
		done("reset");
		for (k = 0; k < 4; k++) begin
			{wiring, mm} = k[1:0];
			vn_e = (k == 0) ? 16'h24F3 : 16'h4000;
			cyc(3);
			exp(10'h000, 10'h000);
		end
		done("nominal");
		for (k = 0; k < 6; k++) begin
			wiring = (k >= 3);
			mm = 1'b0;
			vn_e = wiring ? 16'h4000 : 16'h24F3;
			v = '{default: vn_e >> 1};
			v[k % 3] = vn_e + 16'h0100;
			setl(v[0], v[1], v[2]);
			exp({3'h4 >> (k % 3), 7'h08});
		end
		setl(16'h4000, 16'h2000, 16'h2000);
		exp(10'h000);
		setl(16'h4001, 16'h2000, 16'h2000);
		exp({3'h4, 7'h08});
		setl(16'h3C00, 16'h2000, 16'h2000);
		exp({3'h4, 7'h08});
		setl(16'h3BFF, 16'h2000, 16'h2000);
		exp(10'h000);
		done("levels");
		for (k = 0; k < 12; k++) begin
			vote = 2'(k % 3);
			m = (k == 11) ? 7 : $urandom % 8;
			c = m[0] + m[1] + m[2];
			for (int j = 0; j < 3; j++)
				v[j] = m[j] ? 16'h4100 + 16'($urandom % 256) : 16'h3000 - 16'($urandom % 256);
			setl(v[0], v[1], v[2]);
			exp({6'h00, c > (k % 3), 3'h0}, 10'h00F);
		end
		vote = VOTE_ANY_ONE;
		setl(16'h2000, 16'h2000, 16'h2000);
		done("vote");
		dly = 32'h0000_0005;
		setl(16'h4100, 16'h2000, 16'h2000);
		exp({3'h4, 3'h4, 4'hC});
		tb_in = 1'b1;
		cyc(2);
		exp({3'h4, 3'h4, 4'hC});
		tperm = 1'b1;
		cyc(2);
		exp({3'h4, 7'h08});
		tb_in = 1'b0;
		cyc(8);
		exp({3'h4, 3'h4, 4'hC});
		psup = 1'b1;
		cyc(2);
		exp({3'h4, 7'h08});
		psup = 1'b0;
		setl(16'h2000, 16'h2000, 16'h2000);
		exp(10'h000);
		done("trip");
		for (k = 0; k < 2; k++) begin
			{ba, bb} = k ? 2'h1 : 2'h2;
			setl(16'h4100, 16'h2000, 16'h2000);
			exp({3'h4, 3'h4, 4'hC});
			eperm = 1'b1;
			cyc(2);
			exp(10'h002);
			{ba, bb, eperm} = 3'h0;
			setl(16'h2000, 16'h2000, 16'h2000);
			exp(10'h000);
		end
		dly = 32'h0000_0FFF;
		done("block");
		mode = MODE_UNDER;
		setl(16'h2000, 16'h2000, 16'h2000);
		exp({3'h7, 7'h08});
		setl(16'h0000, 16'h0000, 16'h0000);
		exp(10'h003);
		mode = MODE_UNUSED;
		cyc(2);
		exp(10'h003);
		mode = 2'h3;
		setl(16'h2000, 16'h2000, 16'h2000);
		exp(10'h002);
		mode = MODE_OVER;
		{fn, fwr} = 2'h1;
		cyc(1);
		fwr = 1'b0;
		cyc(3);
		exp(10'h002);
		{fn, fwr} = 2'h3;
		cyc(1);
		fwr = 1'b0;
		cyc(3);
		exp(10'h000);
		done("function");
		harm = 16'h0200; // true RMS sees a harmonic share that the fundamental lacks
		setl(16'h3F00, 16'h2000, 16'h2000);
		exp(10'h000);
		meth = METHOD_RMS;
		cyc(12);
		exp({3'h4, 7'h08});
		{harm, meth} = {16'h0000, METHOD_FUND};
		setl(16'h2000, 16'h2000, 16'h2000);
		exp(10'h000);
		done("method");
		{meth, mode} = {METHOD_AVG, MODE_UNDER};
		cyc(100);
		exp({3'h7, 7'h08});
		setl(16'h5000, 16'h5000, 16'h5000);
		exp({3'h7, 7'h08});
		cyc(100);
		exp(10'h000);
		done("average");
		report_and_stop();
	end
endmodule : voltage_protection_stage_tb_top

bind voltage_protection_stage voltage_protection_stage_properties #(
	.AVG_SLOT_CYCLES(AVG_SLOT_CYCLES)
) chk (
	.clk_sys_i, .rst_n_i, .transformer_wiring_setting_i, .vt_secondary_rating_i,
	.stage_mode_i, .meas_mode_i, .vote_mode_i, .trip_delay_i, .external_block_permission_i,
	.external_trip_block_permission_i, .permanent_trip_suppress_i, .external_block_input_a_i,
	.external_block_input_b_i, .external_trip_block_input_i, .stage_alarm_phase_a_o,
	.stage_alarm_phase_b_o, .stage_alarm_phase_c_o, .stage_trip_phase_a_o, .stage_alarm_o,
	.stage_trip_o, .stage_blocked_o, .loss_of_potential_supervisor_o,
	.nominal_voltage_reference_o
);
`default_nettype wire
